// File: amc_ctrl.sv
// Purpose: Mode and clock-source control of a sigma-delta converter
// Assumes: Register traffic arrives already decoded from the serial port
// Notes:   Filter and modulator themselves sit outside; this block times them
`timescale 1ns/1ps
`include "amc_map.svh"
module amc_ctrl
	import amc_pkg::*;
#(
	parameter int DATA_W     = 24,
	parameter int SETTLE_CYC = `AMC_SETTLE_CYC,
	parameter int OSC_HALF   = `AMC_OSC_HALF_CYC
) (
	input  wire logic              i_mclk,
	input  wire logic              i_resetn,
	input  wire logic              i_ce,
	input  wire logic              i_mode_wr,
	input  wire logic [15:0]       i_mode_wdata,
	input  wire logic              i_restart,
	input  wire logic              i_data_rd,
	input  wire logic              i_cont_read,
	input  wire logic              i_sclk_tick,
	input  wire logic [DATA_W-1:0] i_filter_result,
	input  wire logic              i_clk_pin,
	output logic [15:0]            o_mode_rdata,
	output logic [DATA_W-1:0]      o_data,
	output logic                   o_data_valid_n,
	output logic                   o_result_strobe,
	output logic                   o_dout,
	output logic                   o_mod_tick,
	output logic                   o_filter_reset,
	output logic                   o_power_on,
	output logic                   o_clock_output_driver,
	output logic                   o_clock_output_driver_oe
);
	// Mode register fields
	amc_mode_t       mode_select_q;
	amc_clksel_t     clksel_q;
	logic [3:0]      rate_select_q;
	amc_state_t      st_q;
	amc_state_t      st_d;

	logic [15:0]     osc_cnt_q;
	logic            osc_q;
	logic            osc_prev_q;
	logic            pin_prev_q;
	logic            ext_div_q;
	logic [31:0]     settle_q;
	logic [1:0]      per_cnt_q;
	logic [DATA_W-1:0] shift_q;

	// Decoded events
	logic            osc_rise;
	logic            pin_rise;
	logic            clk_run;
	logic            tick;
	logic            period;
	logic            timer_clear;
	logic            settle_done;
	logic            result_now;
	logic [15:0]     rate_limit;
	logic            in_pdown;
	amc_mode_t       wr_mode;
	logic [15:0]     mode_rd;

	// Rate code to converter clocks per period at 64 kHz
	function automatic logic [15:0] rate_clocks(input logic [3:0] code);
		logic [15:0] n;
		n = 16'h0000;
		unique case (code)
			4'h0: n = 16'h0000;
			4'h1: n = 16'd136;
			4'h2: n = 16'd264;
			4'h3: n = 16'd520;
			4'h4: n = 16'd1032;
			4'h5: n = 16'd1280;
			4'h6: n = 16'd1641;
			4'h7: n = 16'd1928;
			4'h8: n = 16'd3265;
			4'h9: n = 16'd3832;
			4'hA: n = 16'd3832;
			4'hB: n = 16'd5120;
			4'hC: n = 16'd6400;
			4'hD: n = 16'd7683;
			4'hE: n = 16'd10240;
			4'hF: n = 16'd15348;
		endcase
		return n;
	endfunction

	assign rate_limit = rate_clocks(rate_select_q);
	assign wr_mode    = amc_mode_t'(i_mode_wdata[`AMC_MODE_MSB:`AMC_MODE_LSB]);

	// Register read image; reserved bits read zero
	assign mode_rd = {mode_select_q, 5'h00, clksel_q, 2'h0, rate_select_q};

	// Clock source selection; pin sampled as a synchronous input
	assign in_pdown = (st_q == AMC_ST_PDOWN);
	assign clk_run  = !in_pdown;
	assign osc_rise = osc_q && !osc_prev_q;
	assign pin_rise = i_clk_pin && !pin_prev_q;
	assign tick = clk_run && (((clksel_q == AMC_CK_INT) || (clksel_q == AMC_CK_INT_OUT)) ? osc_rise :
		(clksel_q == AMC_CK_EXT) ? pin_rise :
		(pin_rise && ext_div_q));

	// Latency counting; writes and restarts begin a fresh two-period wait
	assign timer_clear = i_mode_wr || i_restart || (st_q == AMC_ST_SETTLE) ||
		(st_q == AMC_ST_IDLE) || in_pdown;
	assign result_now  = period && (per_cnt_q >= 2'(`AMC_FIRST_PERIODS - 1)) && !i_mode_wr && !i_restart &&
		((st_q == AMC_ST_CONT) || (st_q == AMC_ST_SINGLE));
	assign settle_done = (settle_q == 32'(SETTLE_CYC - 1));

	amc_rate_timer #(
		.W(16)
	) u_timer (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_ce     (i_ce),
		.i_clear  (timer_clear),
		.i_tick   (tick),
		.i_limit  (rate_limit),
		.o_period (period)
	);

	// Next state; a mode write always wins over automatic steps
	always_comb begin
		st_d = st_q;
		if (i_mode_wr) begin
			unique case (wr_mode)
				AMC_MD_CONT:   st_d = AMC_ST_CONT;
				AMC_MD_SINGLE: st_d = AMC_ST_SETTLE;
				AMC_MD_IDLE:   st_d = AMC_ST_IDLE;
				AMC_MD_PDOWN:  st_d = AMC_ST_PDOWN;
				default:       st_d = AMC_ST_IDLE;
			endcase
		end else begin
			unique case (st_q)
				AMC_ST_SETTLE: if (settle_done) begin
					st_d = AMC_ST_SINGLE;
				end
				AMC_ST_SINGLE: if (result_now) begin
					st_d = AMC_ST_PDOWN;
				end
				default: st_d = st_q;
			endcase
		end
	end

	// Mode register and state
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_select_q <= amc_mode_t'(3'(`AMC_MODE_RESET >> `AMC_MODE_LSB));
			clksel_q      <= amc_clksel_t'(2'(`AMC_MODE_RESET >> `AMC_CLKSEL_LSB));
			rate_select_q <= 4'(`AMC_MODE_RESET);
			st_q          <= AMC_ST_CONT;
		end else if (i_ce) begin
			if (i_mode_wr) begin
				mode_select_q <= wr_mode;
				clksel_q      <= amc_clksel_t'(i_mode_wdata[`AMC_CLKSEL_MSB:`AMC_CLKSEL_LSB]);
				rate_select_q <= i_mode_wdata[`AMC_RATE_MSB:`AMC_RATE_LSB];
			end
			st_q <= st_d;
		end
	end

	// Internal oscillator model; stops in power-down to save its edges
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			osc_cnt_q  <= 16'h0000;
			osc_q      <= 1'b0;
			osc_prev_q <= 1'b0;
		end else if (i_ce) begin
			osc_prev_q <= osc_q;
			if (!clk_run) begin
				osc_cnt_q <= 16'h0000;
				osc_q     <= 1'b0;
			end else if (osc_cnt_q == 16'(OSC_HALF - 1)) begin
				osc_cnt_q <= 16'h0000;
				osc_q     <= !osc_q;
			end else begin
				osc_cnt_q <= osc_cnt_q + 16'h0001;
			end
		end
	end

	// External pin edge detect and divide by two
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_prev_q <= 1'b0;
			ext_div_q  <= 1'b0;
		end else if (i_ce) begin
			pin_prev_q <= i_clk_pin;
			if (pin_rise) begin
				ext_div_q <= !ext_div_q;
			end
		end
	end

	// Settle counter and period count since last restart
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			settle_q  <= 32'h0000_0000;
			per_cnt_q <= 2'h0;
		end else if (i_ce) begin
			settle_q <= (st_q == AMC_ST_SETTLE && !i_mode_wr) ? settle_q + 32'h0000_0001 : 32'h0000_0000;
			if (timer_clear) begin
				per_cnt_q <= 2'h0;
			end else if (period && per_cnt_q != 2'h3) begin
				per_cnt_q <= per_cnt_q + 2'h1;
			end
		end
	end

	// Data register and ready; new result wins over a read in the same cycle
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_data          <= '0;
			o_data_valid_n  <= 1'b1;
			o_result_strobe <= 1'b0;
		end else if (i_ce) begin
			o_result_strobe <= result_now;
			if (result_now) begin
				o_data         <= i_filter_result;
				o_data_valid_n <= 1'b0;
			end else if (i_mode_wr || (st_d == AMC_ST_PDOWN && !in_pdown) || i_data_rd) begin
				o_data_valid_n <= 1'b1;
			end
		end
	end

	// Continuous read shifter; host stays with read requests when off
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			shift_q <= '0;
			o_dout  <= 1'b0;
		end else if (i_ce) begin
			if (result_now && i_cont_read) begin
				shift_q <= i_filter_result;
				o_dout  <= i_filter_result[DATA_W-1];
			end else if (i_sclk_tick && i_cont_read) begin
				shift_q <= {shift_q[DATA_W-2:0], 1'b0};
				o_dout  <= shift_q[DATA_W-2];
			end
		end
	end

	// Registered outward controls
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_mode_rdata             <= `AMC_MODE_RESET;
			o_mod_tick               <= 1'b0;
			o_filter_reset           <= 1'b1;
			o_power_on               <= 1'b0;
			o_clock_output_driver    <= 1'b0;
			o_clock_output_driver_oe <= 1'b0;
		end else if (i_ce) begin
			o_mode_rdata   <= mode_rd;
			o_mod_tick     <= tick;
			o_filter_reset <= (st_q != AMC_ST_CONT && st_q != AMC_ST_SINGLE) || i_mode_wr || i_restart;
			o_power_on     <= !in_pdown;
			o_clock_output_driver    <= osc_q && (clksel_q == AMC_CK_INT_OUT) && !in_pdown;
			o_clock_output_driver_oe <= (clksel_q == AMC_CK_INT_OUT) && !in_pdown;
		end
	end
endmodule

// File: amc_ctrl_properties.sv
// Purpose: Port-level checks on the mode and clock control
// Assumes: One clock domain, async active-low reset
// Notes:   Four cycles of margin absorb converter tick phase
`timescale 1ns/1ps
module amc_ctrl_properties #(
	parameter int DATA_W     = 24,
	parameter int SETTLE_CYC = 20,
	parameter int OSC_HALF   = 2
) (
	input wire logic              i_mclk,
	input wire logic              i_resetn,
	input wire logic              i_ce,
	input wire logic              i_mode_wr,
	input wire logic [15:0]       i_mode_wdata,
	input wire logic              i_restart,
	input wire logic              i_data_rd,
	input wire logic              i_cont_read,
	input wire logic [15:0]       o_mode_rdata,
	input wire logic [DATA_W-1:0] o_data,
	input wire logic              o_data_valid_n,
	input wire logic              o_result_strobe,
	input wire logic              o_filter_reset,
	input wire logic              o_power_on,
	input wire logic              o_clock_output_driver_oe
);
	localparam int PER = 136 * 2 * OSC_HALF - 4;
	logic [15:0] cnt_q;
	logic        fresh_q;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);

	// Cycles since the last write, restart or result
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q   <= 16'h0000;
			fresh_q <= 1'b1;
		end else if ((i_ce && (i_mode_wr || i_restart)) || o_result_strobe) begin
			cnt_q   <= 16'h0000;
			fresh_q <= !o_result_strobe;
		end else if (cnt_q != 16'hFFFF) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	chk_write_ready: assert property (i_ce && i_mode_wr |=> o_data_valid_n && o_filter_reset)
		else $error("mode write left ready low");
	chk_rdata_image: assert property (i_ce && i_mode_wr ##1 i_ce |=>
		o_mode_rdata == ($past(i_mode_wdata, 2) & 16'hE0CF)) else $error("mode image wrong");
	chk_strobe_ready: assert property (o_result_strobe |-> !o_data_valid_n)
		else $error("result without ready");
	chk_clock_output_driver_sel: assert property (o_clock_output_driver_oe && !$past(i_mode_wr) |->
		o_power_on && o_mode_rdata[7:6] == 2'h1) else $error("clock out in wrong mode");
	chk_result_spacing: assert property (o_result_strobe |-> cnt_q >= (fresh_q ?
		2 * PER + (o_mode_rdata[15:13] == 3'h1 ? SETTLE_CYC : 0) : PER)) else $error("result early");
	chk_pdown_entry: assert property (i_ce && i_mode_wr && i_mode_wdata[15:13] == 3'h3 |->
		##[1:3] !o_power_on && o_data_valid_n) else $error("power-down not entered");
	chk_single_hold: assert property (!o_data_valid_n && !o_power_on && !i_data_rd && !i_mode_wr |=>
		!o_data_valid_n && $stable(o_data)) else $error("held result lost");
	chk_idle_quiet: assert property (o_filter_reset |-> !o_result_strobe)
		else $error("result while filter reset");

	c_single: cover property ($fell(o_power_on) && !o_data_valid_n);
	c_clock_output_driver: cover property (o_clock_output_driver_oe);
	c_cont:   cover property (o_result_strobe && i_cont_read);
endmodule

bind amc_ctrl amc_ctrl_properties #(.DATA_W(DATA_W), .SETTLE_CYC(SETTLE_CYC), .OSC_HALF(OSC_HALF))
	i_amc_ctrl_properties (.i_mclk, .i_resetn, .i_ce, .i_mode_wr, .i_mode_wdata, .i_restart, .i_data_rd,
	.i_cont_read, .o_mode_rdata, .o_data, .o_data_valid_n, .o_result_strobe, .o_filter_reset, .o_power_on,
	.o_clock_output_driver_oe);

// File: amc_ctrl_tb_top.sv
// Purpose: Self-checking bench for the mode and clock control
// Assumes: Settle and oscillator counts shortened
// Notes:   One period at rate code 1 is 544 master cycles here
`timescale 1ns/1ps
module amc_ctrl_tb_top;
	typedef struct {logic [15:0] w, rd; logic oe, fr, pw;} amc_row_t;
	logic        i_mclk, i_resetn, i_ce, i_mode_wr, i_restart, i_data_rd, i_cont_read, i_sclk_tick, i_clk_pin;
	logic        o_data_valid_n, o_result_strobe, o_dout, o_mod_tick, o_filter_reset, o_power_on;
	logic        o_clock_output_driver, o_clock_output_driver_oe, host_run, host_pin;
	logic [15:0] i_mode_wdata, o_mode_rdata;
	logic [23:0] i_filter_result, o_data, got;
	int          errors, n_tests, cyc, n, m;
	amc_row_t    rows [5] = '{'{16'h0001, 16'h0001, 0, 0, 1}, '{16'h0041, 16'h0041, 1, 0, 1},
		'{16'h4041, 16'h4041, 1, 1, 1}, '{16'h6041, 16'h6041, 0, 1, 0}, '{16'hFF0F, 16'hE00F, 0, 1, 1}};

	// Pin level from both drivers
	assign i_clk_pin = o_clock_output_driver_oe ? o_clock_output_driver : host_pin;
	amc_ctrl #(.SETTLE_CYC(20), .OSC_HALF(2)) i_amc_ctrl (.i_mclk, .i_resetn, .i_ce, .i_mode_wr, .i_mode_wdata,
		.i_restart, .i_data_rd, .i_cont_read, .i_sclk_tick, .i_filter_result, .i_clk_pin, .o_mode_rdata, .o_data,
		.o_data_valid_n, .o_result_strobe, .o_dout, .o_mod_tick, .o_filter_reset, .o_power_on,
		.o_clock_output_driver, .o_clock_output_driver_oe);
	amc_host_model #(.HALF(2)) i_amc_host_model (.i_mclk, .i_resetn, .i_run(host_run), .o_pin(host_pin));

	task automatic chk(string nm, logic [23:0] exp, logic [23:0] seen);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rng(string nm, int lo, int hi);
		chk(nm, 24'h000001, 24'((n >= lo) && (n <= hi)));
	endtask
	task automatic wr(logic [15:0] w);
		@(posedge i_mclk);
		i_mode_wr <= 1'b1;
		i_mode_wdata <= w;
		@(posedge i_mclk);
		i_mode_wr <= 1'b0;
	endtask
	// Bounded wait, n holds the cycles taken
	task automatic wait_strobe();
		n = 0;
		do begin
			@(negedge i_mclk);
			n++;
		end while (o_result_strobe !== 1'b1 && n < 4000);
	endtask
	task automatic conclude();
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	// Run ceiling well above the expected sixteen thousand cycles
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			conclude();
		end
	end

	initial begin
		{i_mode_wr, i_restart, i_data_rd, i_cont_read, i_sclk_tick, host_run, i_resetn} = 7'h00;
		i_ce = 1'b1;
		i_mode_wdata = 16'h0000;
		i_filter_result = 24'hA5C30F;
		repeat (16) @(posedge i_mclk);
		chk("reset", 24'h000A11, {o_mode_rdata, 3'h0, o_data_valid_n, o_power_on, o_clock_output_driver_oe, 2'h1});
		i_resetn <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			wr(rows[k].w);
			repeat (3) @(negedge i_mclk);
			chk("row", {rows[k].rd, rows[k].oe, rows[k].fr, rows[k].pw},
				{o_mode_rdata, o_clock_output_driver_oe, o_filter_reset, o_power_on});
		end
		@(posedge i_mclk) i_cont_read <= 1'b1;
		wr(16'h0001);
		wait_strobe();
		rng("first", 1078, 1100);
		chk("data", 24'hA5C30F, o_data);
		wait_strobe();
		rng("gap", 540, 548);
		@(negedge i_mclk);
		got = 24'(o_dout);
		repeat (23) begin
			@(posedge i_mclk) i_sclk_tick <= 1'b1;
			@(posedge i_mclk) i_sclk_tick <= 1'b0;
			@(negedge i_mclk) got = {got[22:0], o_dout};
		end
		chk("serial", 24'hA5C30F, got);
		// Channel change restarts the two-period wait
		@(posedge i_mclk) i_restart <= 1'b1;
		@(posedge i_mclk) i_restart <= 1'b0;
		wait_strobe();
		rng("restart", 1078, 1100);
		wr(16'h0001);
		@(negedge i_mclk);
		chk("ready", 24'h000001, 24'(o_data_valid_n));
		@(posedge i_mclk) i_cont_read <= 1'b0;
		// External pin direct and halved
		host_run <= 1'b1;
		for (int j = 1; j <= 2; j++) begin
			wr(j == 1 ? 16'h0081 : 16'h00C1);
			wait_strobe();
			wait_strobe();
			rng("ext", 544 * j - 4, 544 * j + 4);
		end
		wr(16'h2001);
		host_run <= 1'b0;
		i_filter_result <= 24'h3C5A96;
		wait_strobe();
		rng("single", 1098, 1120);
		repeat (50) @(negedge i_mclk);
		chk("held", 24'h3C5A96, {o_power_on, o_data_valid_n, o_data[21:0]});
		@(posedge i_mclk) i_data_rd <= 1'b1;
		@(posedge i_mclk) i_data_rd <= 1'b0;
		@(negedge i_mclk);
		chk("read", 24'h000001, 24'(o_data_valid_n));
		// Rate code 2, then the invalid code 0 which never yields a result
		wr(16'h0002);
		wait_strobe();
		wait_strobe();
		rng("rate2", 1052, 1060);
		wr(16'h0000);
		wait_strobe();
		rng("rate0", 4000, 4000);
		// Clock pin output and converter ticks over ten oscillator periods
		wr(16'h0040);
		repeat (4) @(negedge i_mclk);
		n = 0;
		m = 0;
		repeat (40) begin
			@(negedge i_mclk);
			if (o_mod_tick === 1'b1) n++;
			if (o_clock_output_driver === 1'b1) m++;
		end
		chk("tick", 24'd10, 24'(n));
		chk("clock_output_driver", 24'd20, 24'(m));
		// Clock enable low: a write is not taken
		wr(16'h4001);
		@(posedge i_mclk) i_ce <= 1'b0;
		wr(16'h0001);
		repeat (3) @(negedge i_mclk);
		chk("freeze", 24'h010007, {o_mode_rdata, o_filter_reset, o_power_on});
		@(posedge i_mclk) i_ce <= 1'b1;
		conclude();
	end
endmodule

// File: amc_host_model.sv
// Purpose: Far-side clock source feeding the clock pin
// Assumes: Pin sampled on the master clock
// Notes:   Half period scaled down like the internal oscillator
`timescale 1ns/1ps
module amc_host_model #(
	parameter int HALF = 2
) (
	input  wire logic i_mclk,
	input  wire logic i_resetn,
	input  wire logic i_run,
	output logic      o_pin
);
	logic [7:0] cnt_q;

	// Stopped source rests low, like an idle clock line
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q <= 8'h00;
			o_pin <= 1'b0;
		end else if (!i_run) begin
			cnt_q <= 8'h00;
			o_pin <= 1'b0;
		end else if (cnt_q == 8'(HALF - 1)) begin
			cnt_q <= 8'h00;
			o_pin <= ~o_pin;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
endmodule

// File: amc_map.svh
// Purpose: Field positions, reset values and timing counts for the mode and clock control
// Assumes: Master clock at 250 MHz
// Notes:   Definitions only
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH

`define AMC_MODE_RESET      16'h000A
`define AMC_MODE_MSB        15
`define AMC_MODE_LSB        13
`define AMC_CLKSEL_MSB      7
`define AMC_CLKSEL_LSB      6
`define AMC_RATE_MSB        3
`define AMC_RATE_LSB        0

`define AMC_MCLK_HZ         250000000
`define AMC_OSC_HZ          64000
`define AMC_OSC_HALF_CYC    (`AMC_MCLK_HZ / (2 * `AMC_OSC_HZ))
`define AMC_SETTLE_US       1000
`define AMC_SETTLE_CYC      ((`AMC_SETTLE_US * (`AMC_MCLK_HZ / 1000000)))
`define AMC_FIRST_PERIODS   2

`endif

// File: amc_pkg.sv
// Purpose: Types shared by the mode and clock control
// Assumes: Used with amc_map.svh
// Notes:   Encodings follow the mode register fields
package amc_pkg;

	typedef enum logic [2:0] {
		AMC_MD_CONT   = 3'h0,
		AMC_MD_SINGLE = 3'h1,
		AMC_MD_IDLE   = 3'h2,
		AMC_MD_PDOWN  = 3'h3
	} amc_mode_t;

	typedef enum logic [1:0] {
		AMC_CK_INT     = 2'h0,
		AMC_CK_INT_OUT = 2'h1,
		AMC_CK_EXT     = 2'h2,
		AMC_CK_EXT_DIV = 2'h3
	} amc_clksel_t;

	typedef enum logic [2:0] {
		AMC_ST_CONT   = 3'h0,
		AMC_ST_SETTLE = 3'h1,
		AMC_ST_SINGLE = 3'h2,
		AMC_ST_IDLE   = 3'h3,
		AMC_ST_PDOWN  = 3'h4
	} amc_state_t;

endpackage

// File: amc_rate_timer.sv
// Purpose: Counts converter clock ticks into output-rate periods
// Assumes: i_tick is a one-cycle pulse per converter clock
// Notes:   A limit of zero never yields a period; the count keeps running on ticks
`timescale 1ns/1ps
module amc_rate_timer #(
	parameter int W = 16
) (
	input  wire logic         i_mclk,
	input  wire logic         i_resetn,
	input  wire logic         i_ce,
	input  wire logic         i_clear,
	input  wire logic         i_tick,
	input  wire logic [W-1:0] i_limit,
	output logic              o_period
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         wrap;

	// Wrap on the last tick of a period
	assign wrap  = i_tick && (i_limit != '0) && (cnt_q == i_limit - W'(1));
	assign cnt_d = i_clear ? '0 : (wrap ? '0 : (i_tick ? cnt_q + W'(1) : cnt_q));

	// Clear restarts the period from zero
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q    <= '0;
			o_period <= 1'b0;
		end else if (i_ce) begin
			cnt_q    <= cnt_d;
			o_period <= wrap && !i_clear;
		end
	end
endmodule
